// ===== shared/fcs_defines.vh
// Constants for the flash configuration and status register group
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Command opcodes
`define FCS_CMD_WRITE_REGS      8'h01
`define FCS_CMD_READ_STATUS_TWO 8'h07
`define FCS_CMD_BOOT_READ       8'h14
`define FCS_CMD_BOOT_WRITE      8'h15
`define FCS_CMD_BANK_READ       8'h16
`define FCS_CMD_BANK_WRITE      8'h17
`define FCS_CMD_BANK_ACCESS     8'hB9
`define FCS_CMD_SECTOR_ERASE    8'h20
`define FCS_CMD_BLOCK_ERASE     8'hD8

// Serial bit counts at chip-select release
`define FCS_CNT_CMD_ONLY        6'h08
`define FCS_CNT_ONE_BYTE        6'h10
`define FCS_CNT_THREE_BYTE      6'h20
`define FCS_CNT_FOUR_BYTE       6'h28
`define FCS_CNT_MAX             6'h3F
`define FCS_CNT_RELOAD_MASK     5'h08

// Status register two fields
`define FCS_SR2_ERASE_SIZE      7
`define FCS_SR2_PAGE_WRAP       6
`define FCS_SR2_PIN3_RESET      5
`define FCS_SR2_ERASE_SUSP      1
`define FCS_SR2_PROG_SUSP       0
`define FCS_SR2_OTP_RESET       3'h0

// Boot-at-reset register fields and reset value
`define FCS_BOOT_ADDR_HI        31
`define FCS_BOOT_ADDR_LO        9
`define FCS_BOOT_DLY_HI         8
`define FCS_BOOT_DLY_LO         1
`define FCS_BOOT_EN             0
`define FCS_BOOT_RESET          32'h00000000

// Bank address register fields and reset value
`define FCS_BANK_EXT            7
`define FCS_BANK_RESET          3'h0

// Protection mode lock: both bits still set means unlocked
`define FCS_MODE_UNLOCKED       2'h3

// Erase size codes and alignment masks
`define FCS_SIZE_4K             2'h0
`define FCS_SIZE_64K            2'h1
`define FCS_SIZE_256K           2'h2
`define FCS_MASK_4K             32'hFFFFF000
`define FCS_MASK_64K            32'hFFFF0000
`define FCS_MASK_256K           32'hFFFC0000
`define FCS_PARAM_TOP_BLOCK     8'hFF
`define FCS_PARAM_BOT_BLOCK     8'h00
`define FCS_ARRAY_TOP_BYTE      8'h00

`endif

// ===== rtl/fcs_sync.v
// Two-flop synchroniser for pins entering the clk domain
`timescale 1ns/10ps
module fcs_sync #(
    parameter       W       = 4,
    parameter [3:0] RST_VAL = 4'h0
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;     // First stage, read only by q

    // Both stages reset to the idle level of each pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL[W-1:0];
            q      <= RST_VAL[W-1:0];
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // fcs_sync

// ===== rtl/fcs_regs.v
// Flash status-two, boot-at-reset and bank address registers over SPI
//
// Contract
// - Status two: read 07h, written by 01h
// - Option bit 7 selects 256k or 64k erase
// - Hybrid: sixteen 4k sectors, 20h and D8h
// - Uniform: aligned 256k blocks erased by D8h
// - Bit 6 selects page wrap 512 or 256
// - Bit 5 picks pin3 reset or hold function
// - Bit 1 reads erase suspend, read only
// - Bit 0 reads program suspend, read only
// - Boot register read 14h, written 15h, kept
// - Bits 31..9 hold aligned boot start address
// - Bits 8..1 hold boot start delay cycles
// - Bit 0 enables boot read on reset
// - Bank register via B9h, 16h, 17h, 01h
// - Extended bit 0: bank bits above A23
// - Extended bit 1: bank ignored, 4-byte address
// - Extended bit volatile, cleared by all resets
// - Quad bit makes pin3 data, no monitoring
// - Locked mode: option program fails, error flag
`timescale 1ns/10ps
`include "fcs_defines.vh"
module fcs_regs (
    input  wire        clk,
    input  wire        rst,
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_si,
    input  wire        hw_reset_n,
    input  wire        sw_reset,
    input  wire        erase_suspended,
    input  wire        program_suspended,
    input  wire        quad_mode,
    input  wire        param_top,
    input  wire [1:0]  mode_lock,
    output reg         spi_so_r,
    output reg         spi_so_oe_n_r,
    output reg         erase_size_option_r,
    output reg         page_wrap_option_r,
    output reg         pin3_reset_option_r,
    output reg         pin3_is_data_r,
    output reg         pin3_reset_en_r,
    output reg         pin3_hold_en_r,
    output reg         hold_wp_monitor_r,
    output reg [22:0]  boot_start_address_r,
    output reg [7:0]   boot_start_delay_r,
    output reg         boot_at_reset_enable_r,
    output reg         boot_fetch_req_r,
    output reg         four_byte_address_enable_r,
    output reg [1:0]   bank_bits_r,
    output reg         erase_req_r,
    output reg [31:0]  erase_addr_r,
    output reg [1:0]   erase_size_r,
    output reg         prog_err_r
);
    // Synchronised pins
    wire [3:0]  pins_s;             // {hw_reset_n, si, cs_n, sck}
    wire        sck_s;              // Serial clock in clk domain
    wire        cs_n_s;             // Chip select in clk domain
    wire        si_s;               // Serial data in clk domain
    wire        hw_rst_n_s;         // Pin reset in clk domain

    // Serial engine state
    reg         sck_d_r;            // Previous serial clock level
    reg         cs_n_d_r;           // Previous chip select level
    reg  [5:0]  cnt_r;              // Bits seen this frame, saturating
    reg  [7:0]  cmd_r;              // Opcode of the frame
    reg  [31:0] data_r;             // Last 32 bits after the opcode
    reg  [31:0] out_sh_r;           // Read data shifter
    reg         bank_pend_r;        // B9h seen, next 01h writes bank

    // Register storage
    reg  [2:0]  otp_r;              // Option bits 7..5, one-time
    reg  [31:0] boot_r;             // Boot-at-reset register
    reg         ext_r;              // Extended address bit
    reg  [1:0]  bank_r;             // Bank bits 25..24
    reg         rst_seen_r;         // Reset active in the previous cycle
    reg  [5:0]  cnt_nxt;            // Next bit count

    wire        sck_rise;           // Sampling edge, mode 0
    wire        sck_fall;           // Launch edge, mode 0
    wire        cs_end;             // Frame closed by chip select
    wire        any_reset;          // Pin or command reset
    wire [31:0] erase_full;         // Erase address after banking
    wire        in_param;           // Address in 4k parameter block

    // Pins leave the pin domain only through the synchroniser
    fcs_sync #(
        .W       (4),
        .RST_VAL (4'hE)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({hw_reset_n, spi_si, spi_cs_n, spi_sck}),
        .q   (pins_s)
    );

    assign sck_s      = pins_s[0];
    assign cs_n_s     = pins_s[1];
    assign si_s       = pins_s[2];
    assign hw_rst_n_s = pins_s[3];

    assign sck_rise  = sck_s & ~sck_d_r & ~cs_n_s;
    assign sck_fall  = ~sck_s & sck_d_r & ~cs_n_s;
    assign cs_end    = cs_n_s & ~cs_n_d_r;
    assign any_reset = sw_reset | ~hw_rst_n_s;

    // Read image of status two: reserved bits forced low
    function [7:0] status_two;
        input [2:0] otp;
        input       es;
        input       ps;
        begin
            status_two = {otp, 3'h0, es, ps};
        end
    endfunction

    // Read image of bank register: reserved bits forced low
    function [7:0] bank_image;
        input       ext;
        input [1:0] bank;
        begin
            bank_image = {ext, 5'h00, bank};
        end
    endfunction

    // Full address: bank bits above A23 unless four-byte mode
    function [31:0] full_addr;
        input        ext;
        input [1:0]  bank;
        input [31:0] raw;
        begin
            if (ext) begin
                full_addr = raw;
            end else begin
                full_addr = {6'h00, bank, raw[23:0]};
            end
        end
    endfunction

    // Four-byte frames carry 32 address bits, otherwise 24
    assign erase_full = full_addr(ext_r, bank_r,
                                  ext_r ? data_r : {8'h00, data_r[23:0]});
    // Sixteen 4k sectors form one 64k block at top or bottom
    assign in_param = (erase_full[31:24] == `FCS_ARRAY_TOP_BYTE) &&
                      (erase_full[23:16] == (param_top ?
                       `FCS_PARAM_TOP_BLOCK : `FCS_PARAM_BOT_BLOCK));

    // Saturating bit counter, so long frames cannot wrap into a match
    always @* begin
        cnt_nxt = cnt_r;
        if (sck_rise && cnt_r != `FCS_CNT_MAX) begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    // Serial input: opcode first, then a 32-bit window of data
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_d_r  <= 1'b0;
            cs_n_d_r <= 1'b1;
            cnt_r    <= 6'h00;
            cmd_r    <= 8'h00;
            data_r   <= 32'h00000000;
        end else begin
            sck_d_r  <= sck_s;
            cs_n_d_r <= cs_n_s;
            if (cs_n_s) begin
                // Idle: next frame starts from bit zero
                cnt_r <= 6'h00;
            end else begin
                cnt_r <= cnt_nxt;
                if (sck_rise) begin
                    if (cnt_r < `FCS_CNT_CMD_ONLY) begin
                        cmd_r <= {cmd_r[6:0], si_s};
                    end else begin
                        data_r <= {data_r[30:0], si_s};
                    end
                end
            end
        end
    end

    // Serial output: reload at bit counts 8 and 40 so short registers repeat
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_sh_r      <= 32'h00000000;
            spi_so_r      <= 1'b0;
            spi_so_oe_n_r <= 1'b1;
        end else if (cs_n_s) begin
            spi_so_oe_n_r <= 1'b1;
            spi_so_r      <= 1'b0;
        end else if (sck_fall && cnt_r >= `FCS_CNT_CMD_ONLY) begin
            if (cnt_r[4:0] == `FCS_CNT_RELOAD_MASK) begin
                // Load on first data bit and once more 32 bits later
                case (cmd_r)
                    `FCS_CMD_READ_STATUS_TWO: begin
                        out_sh_r      <= {4{status_two(otp_r,
                                           erase_suspended,
                                           program_suspended)}};
                        spi_so_oe_n_r <= 1'b0;
                    end
                    `FCS_CMD_BOOT_READ: begin
                        out_sh_r      <= boot_r;
                        spi_so_oe_n_r <= 1'b0;
                    end
                    `FCS_CMD_BANK_READ: begin
                        out_sh_r      <= {4{bank_image(ext_r, bank_r)}};
                        spi_so_oe_n_r <= 1'b0;
                    end
                    default: begin
                        // Not a read: pin stays released
                        out_sh_r      <= 32'h00000000;
                        spi_so_oe_n_r <= 1'b1;
                    end
                endcase
                case (cmd_r)
                    `FCS_CMD_READ_STATUS_TWO: begin
                        spi_so_r <= otp_r[2];
                    end
                    `FCS_CMD_BOOT_READ: begin
                        spi_so_r <= boot_r[31];
                    end
                    `FCS_CMD_BANK_READ: begin
                        spi_so_r <= ext_r;
                    end
                    default: begin
                        spi_so_r <= 1'b0;
                    end
                endcase
            end else begin
                // Shift MSB first on every launch edge
                out_sh_r <= {out_sh_r[30:0], 1'b0};
                spi_so_r <= out_sh_r[30];
            end
        end
    end

    // One-time option bits and the program error pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            otp_r      <= `FCS_SR2_OTP_RESET;
            prog_err_r <= 1'b0;
        end else begin
            prog_err_r <= 1'b0;
            // Only a 32-bit write frame (opcode plus three bytes) may touch the option bits
            if (cs_end && cmd_r == `FCS_CMD_WRITE_REGS &&
                cnt_r == `FCS_CNT_THREE_BYTE && !bank_pend_r) begin
                if (mode_lock != `FCS_MODE_UNLOCKED) begin
                    // Locked: any attempt to program fails
                    if ((data_r[7:5] & ~otp_r) != 3'h0) begin
                        prog_err_r <= 1'b1;
                    end
                end else begin
                    otp_r <= otp_r | data_r[7:5];
                end
            end
        end
    end

    // Boot register: not touched by pin or command reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_r <= `FCS_BOOT_RESET;
        end else if (cs_end && cmd_r == `FCS_CMD_BOOT_WRITE &&
                     cnt_r == `FCS_CNT_FOUR_BYTE) begin
            // Stored as written: bits 8..0 carry delay and enable, address starts at bit 9
            boot_r <= {data_r[`FCS_BOOT_ADDR_HI:`FCS_BOOT_ADDR_LO],
                       data_r[`FCS_BOOT_DLY_HI:`FCS_BOOT_DLY_LO],
                       data_r[`FCS_BOOT_EN]};
        end
    end

    // Bank register: volatile, cleared by every kind of reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_r       <= 1'b0;
            bank_r      <= 2'h0;
            bank_pend_r <= 1'b0;
        end else if (any_reset) begin
            ext_r       <= 1'b0;
            bank_r      <= 2'h0;
            bank_pend_r <= 1'b0;
        end else if (cs_end) begin
            if (cmd_r == `FCS_CMD_BANK_ACCESS &&
                cnt_r == `FCS_CNT_CMD_ONLY) begin
                // Arms the next write-registers frame for the bank
                bank_pend_r <= 1'b1;
            end else if ((cmd_r == `FCS_CMD_BANK_WRITE ||
                          (cmd_r == `FCS_CMD_WRITE_REGS && bank_pend_r))
                         && cnt_r == `FCS_CNT_ONE_BYTE) begin
                ext_r       <= data_r[`FCS_BANK_EXT];
                bank_r      <= data_r[1:0];
                bank_pend_r <= 1'b0;
            end else if (cmd_r == `FCS_CMD_WRITE_REGS) begin
                bank_pend_r <= 1'b0;
            end
        end
    end

    // Erase decode: size from the option bit, aligned base address
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_req_r  <= 1'b0;
            erase_addr_r <= 32'h00000000;
            erase_size_r <= `FCS_SIZE_64K;
        end else begin
            erase_req_r <= 1'b0;
            if (cs_end && ((!ext_r && cnt_r == `FCS_CNT_THREE_BYTE) ||
                           (ext_r && cnt_r == `FCS_CNT_FOUR_BYTE))) begin
                if (cmd_r == `FCS_CMD_BLOCK_ERASE) begin
                    erase_req_r <= 1'b1;
                    if (otp_r[2]) begin
                        erase_addr_r <= erase_full & `FCS_MASK_256K;
                        erase_size_r <= `FCS_SIZE_256K;
                    end else begin
                        erase_addr_r <= erase_full & `FCS_MASK_64K;
                        erase_size_r <= `FCS_SIZE_64K;
                    end
                end else if (cmd_r == `FCS_CMD_SECTOR_ERASE &&
                             !otp_r[2] && in_param) begin
                    // Small sectors exist only in the hybrid block
                    erase_req_r  <= 1'b1;
                    erase_addr_r <= erase_full & `FCS_MASK_4K;
                    erase_size_r <= `FCS_SIZE_4K;
                end
            end
        end
    end

    // Pin 3 function latched at every reset; data use overrides it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_seen_r          <= 1'b1;
            pin3_reset_option_r <= 1'b0;
            boot_fetch_req_r    <= 1'b0;
        end else begin
            rst_seen_r       <= any_reset;
            boot_fetch_req_r <= 1'b0;
            // Sampled on release so the strap follows the stored option
            if (rst_seen_r && !any_reset) begin
                pin3_reset_option_r <= otp_r[0];
                boot_fetch_req_r    <= boot_r[`FCS_BOOT_EN];
            end
        end
    end

    // Registered views of the configuration for the rest of the die
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            erase_size_option_r        <= 1'b0;
            page_wrap_option_r         <= 1'b0;
            pin3_is_data_r             <= 1'b0;
            pin3_reset_en_r            <= 1'b0;
            pin3_hold_en_r             <= 1'b0;
            hold_wp_monitor_r          <= 1'b0;
            boot_start_address_r       <= 23'h000000;
            boot_start_delay_r         <= 8'h00;
            boot_at_reset_enable_r     <= 1'b0;
            four_byte_address_enable_r <= 1'b0;
            bank_bits_r                <= 2'h0;
        end else begin
            erase_size_option_r <= otp_r[2];
            page_wrap_option_r  <= otp_r[1];
            pin3_is_data_r      <= quad_mode;
            hold_wp_monitor_r   <= ~quad_mode;
            // Alternate function only while the pin carries no data
            pin3_reset_en_r <= pin3_reset_option_r & ~quad_mode;
            pin3_hold_en_r  <= ~pin3_reset_option_r & ~quad_mode;
            boot_start_address_r <=
                boot_r[`FCS_BOOT_ADDR_HI:`FCS_BOOT_ADDR_LO];
            boot_start_delay_r <=
                boot_r[`FCS_BOOT_DLY_HI:`FCS_BOOT_DLY_LO];
            boot_at_reset_enable_r     <= boot_r[`FCS_BOOT_EN];
            four_byte_address_enable_r <= ext_r;
            // Bank bits are meaningless in four-byte mode
            bank_bits_r <= ext_r ? 2'h0 : bank_r;
        end
    end
endmodule // fcs_regs

// ===== tb/fcs_host.sv
// Host controller model driving register frames on the serial link
`timescale 1ns/10ps
module fcs_host (
    output reg  spi_sck,
    output reg  spi_cs_n,
    output reg  spi_si,
    input  wire spi_so,
    input  wire spi_so_oe_n
);
    // Mode 0: clock rests low between frames, select high
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    // Opcode and payload MSB first; answer bits gathered on rises
    task xfer(input [39:0] f, input integer n, output [39:0] rd);
        integer i;
        begin
            rd = 40'h0;
            #13;
            spi_cs_n = 1'b0;
            #160;
            for (i = 0; i < n; i = i + 1) begin
                spi_si = f[39-i];
                #160;
                spi_sck = 1'b1;
                // Undriven line reads as inverse of the last bit
                rd = {rd[38:0], spi_so_oe_n ? ~rd[0] : spi_so};
                #160;
                spi_sck = 1'b0;
            end
            #160;
            spi_cs_n = 1'b1;
            spi_si = ~spi_si; // No stale value outside frames
            #640;
        end
    endtask
endmodule // fcs_host

// ===== tb/fcs_regs_chk.sv
// Concurrent checks on the register group's ports
`timescale 1ns/10ps
module fcs_regs_chk (
    input wire        clk,
    input wire        rst,
    input wire        spi_cs_n,
    input wire        sw_reset,
    input wire        quad_mode,
    input wire [1:0]  mode_lock,
    input wire        spi_so_oe_n_r,
    input wire        erase_size_option_r,
    input wire        page_wrap_option_r,
    input wire        pin3_is_data_r,
    input wire        pin3_reset_en_r,
    input wire        pin3_hold_en_r,
    input wire        hold_wp_monitor_r,
    input wire        boot_at_reset_enable_r,
    input wire        boot_fetch_req_r,
    input wire        four_byte_address_enable_r,
    input wire [1:0]  bank_bits_r,
    input wire        erase_req_r,
    input wire [31:0] erase_addr_r,
    input wire [1:0]  erase_size_r,
    input wire        prog_err_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_oe_idle: assert property (spi_cs_n [*5] |-> spi_so_oe_n_r)
        else $error("data out driven while deselected");
    a_quad_pin: assert property ($stable(quad_mode) [*3] |->
        pin3_is_data_r == quad_mode && hold_wp_monitor_r != quad_mode)
        else $error("pin3 data role wrong");
    a_quad_noalt: assert property (quad_mode [*3] |->
        !pin3_reset_en_r && !pin3_hold_en_r)
        else $error("alternate function active in quad");
    a_ext_nobank: assert property (four_byte_address_enable_r &&
        $past(four_byte_address_enable_r) |-> bank_bits_r == 2'h0)
        else $error("bank bits used in four byte mode");
    a_sw_clear: assert property (sw_reset |->
        ##[1:4] !four_byte_address_enable_r)
        else $error("extended bit kept over reset");
    a_boot_pulse: assert property (boot_fetch_req_r |->
        boot_at_reset_enable_r ##1 !boot_fetch_req_r)
        else $error("boot request wrong");
    a_err_locked: assert property (prog_err_r |->
        mode_lock != 2'h3 ##1 !prog_err_r)
        else $error("program error while unlocked");
    a_otp_sticky: assert property ((erase_size_option_r |=>
        erase_size_option_r) and (page_wrap_option_r |=> page_wrap_option_r))
        else $error("option bit cleared");
    a_erase_uni: assert property (erase_req_r &&
        erase_size_option_r |-> erase_size_r == 2'h2)
        else $error("uniform erase size wrong");
    a_erase_align: assert property (erase_req_r &&
        erase_size_r == 2'h2 |-> erase_addr_r[17:0] == 18'h0)
        else $error("large erase not aligned");
    c_boot: cover property (boot_fetch_req_r);
    c_err: cover property (prog_err_r);
    c_erase: cover property (erase_req_r && erase_size_r == 2'h2);
endmodule // fcs_regs_chk
bind fcs_regs fcs_regs_chk u_chk (.*);

// ===== tb/fcs_regs_tb.sv
// Self-checking bench for the flash register group
`timescale 1ns/10ps
`define CHK(n,e,a) begin compares = compares + 1; if ((a) !== (e)) begin \
 fails = fails + 1; $display("mismatch %0s exp %0h got %0h", n, e, a); end end
module fcs_regs_tb;
    reg         clk = 1'b0;        // 25 MHz
    reg         rst = 1'b1;
    reg         hw_n = 1'b1;       // Pin reset, active low
    reg         sw = 1'b0;         // Command reset pulse
    reg         es = 1'b0, ps = 1'b0, quad = 1'b0;
    reg  [1:0]  lock = 2'h3;       // Unlocked
    wire        sck, cs_n, si, so, oe_n, eso, pwo, p3o, p3d, p3r, p3h;
    wire        hwm, ben, bfr, ext, ereq, perr;
    wire [22:0] bsa;
    wire [7:0]  bsd;
    wire [1:0]  bank, esz;
    wire [31:0] eadr;
    integer     fails = 0, compares = 0, cyc = 0, nb = 0, ne = 0, ner = 0;
    integer     i, n;
    reg  [31:0] seed = 32'h00007682, r, ea;
    reg  [1:0]  ez;
    reg  [39:0] rd;
    always #20 clk = ~clk;
    fcs_host host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
        .spi_so(so), .spi_so_oe_n(oe_n));
    fcs_regs uut (.clk(clk), .rst(rst), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_si(si), .hw_reset_n(hw_n), .sw_reset(sw),
        .erase_suspended(es), .program_suspended(ps), .quad_mode(quad),
        .param_top(1'b0), .mode_lock(lock), .spi_so_r(so),
        .spi_so_oe_n_r(oe_n), .erase_size_option_r(eso),
        .page_wrap_option_r(pwo), .pin3_reset_option_r(p3o),
        .pin3_is_data_r(p3d), .pin3_reset_en_r(p3r), .pin3_hold_en_r(p3h),
        .hold_wp_monitor_r(hwm), .boot_start_address_r(bsa),
        .boot_start_delay_r(bsd), .boot_at_reset_enable_r(ben),
        .boot_fetch_req_r(bfr), .four_byte_address_enable_r(ext),
        .bank_bits_r(bank), .erase_req_r(ereq), .erase_addr_r(eadr),
        .erase_size_r(esz), .prog_err_r(perr));
    // Pulse counters; the timeout guards against a hung link
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bfr) nb <= nb + 1;
        if (perr) ner <= ner + 1;
        if (ereq) begin
            ne <= ne + 1;
            ea <= eadr;
            ez <= esz;
        end
        if (cyc == 40000) begin
            fails = fails + 1;
            summarize;
        end
    end
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    // Expected 256k block base; 3-byte mode puts bank above A23
    function [31:0] eexp(input [31:0] a, input e, input [1:0] b);
        eexp = (e ? a : {6'h0, b, a[23:0]}) & 32'hFFFC0000;
    endfunction
    task x(input [7:0] op, input [31:0] d, input integer nb_bits);
        host.xfer({op, d}, nb_bits, rd);
    endtask
    task rstp(input hw);
        begin
            @(posedge clk);
            #1 {hw_n, sw} = hw ? 2'b00 : 2'b11;
            repeat (4) @(posedge clk);
            #1 {hw_n, sw} = 2'b10;
            repeat (10) @(posedge clk);
        end
    endtask
    task tend(input [63:0] s);
        $display("test %0s done", s);
    endtask
    task summarize;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        x(8'h07, 0, 16);
        `CHK("sr2", 8'h00, rd[7:0])
        x(8'h14, 0, 40);
        `CHK("boot", 32'h0, rd[31:0])
        x(8'h16, 0, 16);
        `CHK("bar", 8'h00, rd[7:0])
        for (i = 0; i < 4; i = i + 1) begin
            #1 {es, ps} = i[1:0];
            x(8'h07, 0, 16);
            `CHK("susp", {6'h0, i[1:0]}, rd[7:0])
        end
        {es, ps} = 2'b00;
        tend("status");
        for (i = 0; i < 5; i = i + 1) begin
            seed = xs(seed);
            r = (i == 0) ? 32'h7F : (i == 1) ? 32'h80 : seed;
            x(8'h17, {r[7:0], 24'h0}, 16);
            x(8'h16, 0, 16);
            `CHK("bar", {r[7], 5'h0, r[1:0]}, rd[7:0])
            `CHK("ext", r[7], ext)
            `CHK("bank", r[7] ? 2'h0 : r[1:0], bank)
        end
        x(8'hB9, 0, 8);
        x(8'h01, {8'h83, 24'h0}, 16);
        x(8'h16, 0, 16);
        `CHK("arm", 8'h83, rd[7:0])
        rstp(0);
        `CHK("swclr", 3'h0, {ext, bank})
        x(8'h17, {8'h81, 24'h0}, 16);
        rstp(1);
        `CHK("hwclr", 3'h0, {ext, bank})
        tend("bank");
        seed = xs(seed);
        r = seed | 32'h1;
        x(8'h15, r, 40);
        x(8'h15, ~r, 32);
        x(8'h14, 0, 40);
        `CHK("bootrd", r, rd[31:0])
        `CHK("bsa", r[31:9], bsa)
        `CHK("bsd", r[8:1], bsd)
        n = nb;
        rstp(0);
        `CHK("fetch", n + 1, nb)
        x(8'h14, 0, 40);
        `CHK("bootkeep", r, rd[31:0])
        tend("boot");
        // Options are chosen here, before any erase is issued
        lock = 2'h1;
        n = ner;
        x(8'h01, {16'h0, 8'hE0, 8'h0}, 32);
        `CHK("perr", n + 1, ner)
        lock = 2'h3;
        x(8'h01, {16'h0, 8'hE0, 8'h0}, 24);
        x(8'h07, 0, 16);
        `CHK("sr2", 8'h00, rd[7:0])
        x(8'h01, {16'h0, 8'hDF, 8'h0}, 32);
        x(8'h07, 0, 16);
        `CHK("sr2", 8'hC0, rd[7:0])
        `CHK("opts", 2'b11, {eso, pwo})
        x(8'h01, {16'h0, 8'h20, 8'h0}, 32);
        x(8'h07, 0, 16);
        `CHK("sr2", 8'hE0, rd[7:0])
        rstp(0);
        `CHK("pin3", 3'b110, {p3o, p3r, p3h})
        #1 quad = 1'b1;
        repeat (4) @(posedge clk);
        `CHK("quad", 4'b1000, {p3d, p3r, p3h, hwm})
        #1 quad = 1'b0;
        tend("options");
        x(8'h17, {8'h02, 24'h0}, 16);
        seed = xs(seed);
        n = ne;
        x(8'hD8, {seed[23:0], 8'h0}, 32);
        `CHK("ecnt", n + 1, ne)
        `CHK("eaddr", eexp(seed, 1'b0, 2'h2), ea)
        `CHK("esize", 2'h2, ez)
        x(8'h20, {seed[23:0], 8'h0}, 32);
        `CHK("small", n + 1, ne)
        x(8'h17, {8'h80, 24'h0}, 16);
        seed = xs(seed);
        x(8'hD8, seed, 40);
        `CHK("eaddr4", eexp(seed, 1'b1, 2'h0), ea)
        tend("erase");
        summarize;
    end
endmodule // fcs_regs_tb
